/* File: rtl/isab_pkg.sv */
// isab_pkg: register map, field positions, reset values and timing counts
// for the isa bus engine; assumes a 100 MHz pclk and a 32-bit apb master.
package isab_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_DMACFG = 8'h10;
	localparam logic [7:0] OFS_DMAADR = 8'h14;
	localparam logic [7:0] OFS_DMACNT = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;

	// control register fields
	localparam int CTL_RSTDRV = 0;
	localparam int CTL_DIV_LSB = 1;
	localparam int CTL_DIV_MSB = 4;
	localparam int CTL_DREQ_POL = 6;
	localparam int CTL_DACK_POL = 7;
	localparam int CTL_PCIB_LSB = 8;
	localparam int CTL_PCIB_MSB = 14;
	localparam logic [15:0] CTRL_RST = 16'h080D;

	// command register fields
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_KIND_MSB = 1;
	localparam int CMD_WIDE = 2;
	localparam int CMD_WR = 3;
	localparam logic [1:0] KIND_MEM = 2'h0;
	localparam logic [1:0] KIND_IO = 2'h1;
	localparam logic [1:0] KIND_REF = 2'h2;

	// dma configuration fields
	localparam int DCF_EN_LSB = 0;
	localparam int DCF_EN_MSB = 7;
	localparam int DCF_FAST = 8;
	localparam int DCF_TOMEM = 9;
	localparam int DCF_AUTO = 10;
	localparam int DCF_EOPIN = 11;

	// address limits
	localparam logic [31:0] ADDR_16M = 32'h0100_0000;
	localparam logic [31:0] ADDR_1M = 32'h0010_0000;

	// cycle lengths in sysclk periods, address phase included
	localparam logic [3:0] LEN_MEM16 = 4'h3;
	localparam logic [3:0] LEN_MEM16_ZW = 4'h2;
	localparam logic [3:0] LEN_B8 = 4'h6;
	localparam logic [3:0] LEN_B8_ZW = 4'h3;
	localparam logic [3:0] LEN_IO16 = 4'h3;
	localparam logic [3:0] LEN_FAST = 4'h2;
	localparam logic [3:0] LEN_REF = 4'h4;

	// preemption time of a non-compatible dma channel
	localparam int CLK_MHZ = 100;
	localparam int PREEMPT_US = 4;
	localparam int PREEMPT_CYC_I = PREEMPT_US * CLK_MHZ;
	localparam logic [8:0] PREEMPT_CYC = 9'(PREEMPT_CYC_I);

	// width of the synchronised pin bundle
	localparam int SYN_W = 39;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_CMD = 4'b0100,
		ST_END = 4'b1000
	} isab_st_type;
endpackage : isab_pkg

/* File: rtl/isab_sync.sv */
// isab_sync: two-flop synchroniser for a bundle of asynchronous pins.
// assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ns
`default_nettype none
module isab_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule : isab_sync
`default_nettype wire

/* File: rtl/isab_bridge.sv */
// isab_bridge: isa expansion-bus engine with dma handshake, apb registers.
// assumes isa pins arrive asynchronously; all outputs are registered.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module isab_bridge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic sysclk,
	output logic bale,
	output logic aen,
	output logic rstdrv,
	output logic [6:0] la_o,
	output logic [19:0] sa_o,
	output logic addr_oe,
	output logic ior_n_o,
	output logic iow_n_o,
	output logic memr_n_o,
	output logic memw_n_o,
	input wire logic memr_n_i,
	input wire logic memw_n_i,
	output logic cmd_oe,
	output logic sbhe_n_o,
	output logic sbhe_n_oe,
	input wire logic sbhe_n_i,
	output logic smemr_n,
	output logic smemw_n,
	input wire logic [6:0] la_i,
	input wire logic memcs16_n_i,
	output logic memcs16_n_o,
	output logic memcs16_n_oe,
	input wire logic master_n,
	input wire logic zerows_n,
	input wire logic iochrdy,
	input wire logic [15:0] sd_i,
	output logic [15:0] sd_o,
	output logic sd_oe,
	input wire logic [7:0] dreq,
	output logic [7:0] dack,
	input wire logic eop_i,
	output logic eop_o,
	output logic eop_oe,
	input wire logic refresh_n_i,
	output logic refresh_n_o,
	output logic refresh_n_oe
);
	import isab_pkg::*;

	typedef struct packed {
		isab_st_type st;
		logic [3:0] divc;
		logic sysclk;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [15:0] ctrl;
		logic [31:0] addr;
		logic [15:0] wdat;
		logic [15:0] rdat;
		logic [3:0] cmd;
		logic go;
		logic [11:0] dcfg;
		logic [31:0] daddr;
		logic [31:0] dbase;
		logic [15:0] dcnt;
		logic [15:0] dcbase;
		logic drun;
		logic granted;
		logic [2:0] chan;
		logic [8:0] ptmr;
		logic cdma;
		logic cref;
		logic cext;
		logic c16;
		logic zws;
		logic swap;
		logic last;
		logic eoph;
		logic tc_seen;
		logic xref;
		logic ref_prev;
		logic [3:0] tcnt;
		logic [31:0] caddr;
		logic [7:0] rfa;
		logic bale;
		logic aen;
		logic ior_n;
		logic iow_n;
		logic memr_n;
		logic memw_n;
		logic sbhe_n;
		logic cmd_oe;
		logic sd_oe;
		logic [15:0] sd_o;
		logic refresh_n;
		logic refresh_oe;
		logic eop_o;
		logic eop_oe;
		logic m16_oe;
		logic smemr_n;
		logic smemw_n;
		logic rstdrv;
		logic [7:0] dack;
	} isab_state_type;

	localparam isab_state_type RST_S = '{
		st: ST_IDLE, ctrl: CTRL_RST, ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1,
		memw_n: 1'b1, sbhe_n: 1'b1, cmd_oe: 1'b1, refresh_n: 1'b1, eop_oe: 1'b1,
		smemr_n: 1'b1, smemw_n: 1'b1, rstdrv: 1'b1, dack: 8'hFF,
		default: '0
	};

	isab_state_type s_ff;
	isab_state_type nxt_s;

	logic [SYN_W-1:0] syn;
	logic [7:0] dreq_s;
	logic zws_n_s;
	logic rdy_s;
	logic mst_n_s;
	logic m16_n_s;
	logic eop_s;
	logic ref_n_s;
	logic memr_n_s;
	logic memw_n_s;
	logic [6:0] la_s;
	logic [15:0] sd_s;
	logic [7:0] reqv;
	logic mst;
	logic se;
	logic acc;
	logic wr_en;
	logic pre_exp;
	logic memok;
	logic zw_now;
	logic [7:0] act;

	isab_sync #(.W(SYN_W)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({dreq, zerows_n, iochrdy, master_n, memcs16_n_i, eop_i, refresh_n_i,
			memr_n_i, memw_n_i, la_i, sd_i}),
		.q(syn)
	);
	assign {dreq_s, zws_n_s, rdy_s, mst_n_s, m16_n_s, eop_s, ref_n_s,
		memr_n_s, memw_n_s, la_s, sd_s} = syn;

	function automatic logic [7:0] onehot(input logic [2:0] ch);
		onehot = 8'h01 << ch;
	endfunction : onehot

	function automatic logic [2:0] pick(input logic [7:0] r);
		pick = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (r[i]) begin
				pick = 3'(i);
			end
		end
	endfunction : pick

	// command-phase length in sysclks for the current cycle
	function automatic logic [3:0] cyc_len(input logic io, input logic w16,
		input logic dma, input logic fast, input logic refr, input logic zw);
		logic [3:0] t;
		t = LEN_B8;
		if (refr) begin
			t = LEN_REF;
		end else if (dma) begin
			t = fast ? LEN_FAST : LEN_B8;
		end else if (io && w16) begin
			t = LEN_IO16;
		end else if (w16) begin
			t = zw ? LEN_MEM16_ZW : LEN_MEM16;
		end else if (zw) begin
			t = LEN_B8_ZW;
		end
		cyc_len = t - 4'h1;
	endfunction : cyc_len

	always_comb begin
		nxt_s = s_ff;
		// polarity select, bit set means active low
		reqv = (dreq_s ^ {8{s_ff.ctrl[CTL_DREQ_POL]}}) & s_ff.dcfg[DCF_EN_MSB:DCF_EN_LSB];
		mst = s_ff.granted & ~mst_n_s;
		acc = psel & penable;
		wr_en = acc & s_ff.pready & pwrite & ~s_ff.pslverr;
		pre_exp = s_ff.dcfg[DCF_FAST] & (s_ff.ptmr == PREEMPT_CYC)
			& (|(reqv & ~onehot(s_ff.chan)));
		memok = ~s_ff.dcfg[DCF_FAST] & (s_ff.caddr < ADDR_16M);
		zw_now = ~zws_n_s & ~(s_ff.cmd[CMD_KIND_LSB] & s_ff.c16) & ~s_ff.cdma & ~s_ff.cref;
		se = 1'b0;

		// sysclk divider, steps taken on the falling edge
		if (s_ff.divc >= s_ff.ctrl[CTL_DIV_MSB:CTL_DIV_LSB]) begin
			nxt_s.divc = 4'h0;
			nxt_s.sysclk = ~s_ff.sysclk;
			se = s_ff.sysclk;
		end else begin
			nxt_s.divc = s_ff.divc + 4'h1;
		end

		// apb slave, answer one cycle into the access phase
		nxt_s.pready = acc & ~s_ff.pready;
		if (acc && !s_ff.pready) begin
			nxt_s.pslverr = 1'b0;
			unique case (paddr)
				OFS_CTRL: nxt_s.prdata = {16'h0000, s_ff.ctrl};
				OFS_CMD: nxt_s.prdata = {28'h0000000, s_ff.cmd};
				OFS_ADDR: nxt_s.prdata = s_ff.addr;
				OFS_DATA: nxt_s.prdata = {16'h0000, s_ff.rdat};
				OFS_DMACFG: nxt_s.prdata = {20'h00000, s_ff.dcfg};
				OFS_DMAADR: nxt_s.prdata = s_ff.daddr;
				OFS_DMACNT: nxt_s.prdata = {16'h0000, s_ff.dcnt};
				OFS_STAT: nxt_s.prdata = {23'h000000, s_ff.chan, s_ff.swap, s_ff.tc_seen,
					s_ff.drun, mst, s_ff.granted, (s_ff.st != ST_IDLE) | s_ff.go};
				default: begin
					nxt_s.prdata = 32'h00000000;
					nxt_s.pslverr = 1'b1;
				end
			endcase
		end
		if (wr_en) begin
			unique case (paddr)
				OFS_CTRL: nxt_s.ctrl = pwdata[15:0];
				OFS_CMD: begin
					if (s_ff.st == ST_IDLE && !s_ff.go && !s_ff.granted) begin
						nxt_s.cmd = pwdata[3:0];
						nxt_s.go = 1'b1;
					end
				end
				OFS_ADDR: nxt_s.addr = pwdata;
				OFS_DATA: nxt_s.wdat = pwdata[15:0];
				OFS_DMACFG: nxt_s.dcfg = pwdata[11:0];
				OFS_DMAADR: begin
					nxt_s.daddr = pwdata;
					nxt_s.dbase = pwdata;
				end
				OFS_DMACNT: begin
					nxt_s.dcnt = pwdata[15:0];
					nxt_s.dcbase = pwdata[15:0];
					nxt_s.drun = 1'b1;
					nxt_s.tc_seen = 1'b0;
				end
				default: ;
			endcase
		end

		// refresh requested by an external master, caught on its falling edge
		nxt_s.ref_prev = ref_n_s;
		if (s_ff.granted && s_ff.dcfg[DCF_FAST] && s_ff.ptmr != PREEMPT_CYC) begin
			nxt_s.ptmr = s_ff.ptmr + 9'h001;
		end

		unique case (s_ff.st)
			ST_IDLE: begin
				if (se) begin
					if (s_ff.granted) begin
						if (pre_exp || (mst_n_s && (!s_ff.drun || !reqv[s_ff.chan]))) begin
							nxt_s.granted = 1'b0;
						end else if (s_ff.drun && mst_n_s) begin
							nxt_s.st = ST_ADDR;
							nxt_s.cdma = 1'b1;
							nxt_s.cref = 1'b0;
							nxt_s.cext = 1'b0;
							nxt_s.caddr = s_ff.daddr;
							nxt_s.last = (s_ff.dcnt == 16'h0000);
							nxt_s.aen = 1'b1;
						end
					end else if (s_ff.xref || s_ff.go) begin
						nxt_s.st = ST_ADDR;
						nxt_s.cdma = 1'b0;
						nxt_s.cext = s_ff.xref;
						nxt_s.cref = s_ff.xref | (s_ff.cmd[CMD_KIND_MSB:CMD_KIND_LSB] == KIND_REF);
						nxt_s.xref = 1'b0;
						nxt_s.go = s_ff.xref & nxt_s.go;
						nxt_s.caddr = s_ff.xref || s_ff.cmd[CMD_KIND_MSB:CMD_KIND_LSB] == KIND_REF
							? {24'h000000, s_ff.rfa} : s_ff.addr;
						nxt_s.aen = nxt_s.cref;
					end else if (|reqv) begin
						nxt_s.granted = 1'b1;
						nxt_s.chan = pick(reqv);
						nxt_s.ptmr = 9'h000;
					end
					if (nxt_s.st == ST_ADDR) begin
						nxt_s.bale = 1'b1;
						nxt_s.sbhe_n = nxt_s.cref
							| ~((s_ff.cmd[CMD_WIDE] & ~nxt_s.cdma) | nxt_s.caddr[0]);
						if (nxt_s.cdma && nxt_s.last && !s_ff.dcfg[DCF_EOPIN]) begin
							nxt_s.eop_o = 1'b1;
							nxt_s.tc_seen = 1'b1;
						end
					end
				end
			end
			ST_ADDR: begin
				if (se) begin
					nxt_s.st = ST_CMD;
					nxt_s.tcnt = 4'h1;
					nxt_s.zws = 1'b0;
					if (s_ff.cref) begin
						nxt_s.memr_n = 1'b0;
						nxt_s.refresh_n = s_ff.cext;
						nxt_s.refresh_oe = ~s_ff.cext;
						nxt_s.sd_oe = 1'b0;
					end else if (s_ff.cdma) begin
						nxt_s.swap = ~m16_n_s;
						if (s_ff.dcfg[DCF_TOMEM]) begin
							nxt_s.ior_n = 1'b0;
							nxt_s.memw_n = ~memok;
						end else begin
							nxt_s.memr_n = ~memok;
							nxt_s.iow_n = 1'b0;
						end
					end else begin
						nxt_s.c16 = s_ff.cmd[CMD_WIDE] & (s_ff.cmd[CMD_KIND_LSB] | ~m16_n_s);
						if (s_ff.cmd[CMD_KIND_LSB]) begin
							nxt_s.ior_n = s_ff.cmd[CMD_WR];
							nxt_s.iow_n = ~s_ff.cmd[CMD_WR];
						end else begin
							nxt_s.memr_n = s_ff.cmd[CMD_WR];
							nxt_s.memw_n = ~s_ff.cmd[CMD_WR];
						end
						nxt_s.sd_oe = s_ff.cmd[CMD_WR];
						nxt_s.sd_o = s_ff.wdat;
					end
				end
			end
			ST_CMD: begin
				if (se && rdy_s) begin
					nxt_s.zws = s_ff.zws | zw_now;
					if (s_ff.cdma && s_ff.dcfg[DCF_EOPIN] && eop_s) begin
						nxt_s.eoph = 1'b1;
					end
					if (s_ff.tcnt >= cyc_len(s_ff.cmd[CMD_KIND_LSB], s_ff.c16, s_ff.cdma,
						s_ff.dcfg[DCF_FAST], s_ff.cref, s_ff.zws | zw_now)) begin
						nxt_s.st = ST_END;
						nxt_s.bale = 1'b0;
						nxt_s.ior_n = 1'b1;
						nxt_s.iow_n = 1'b1;
						nxt_s.memr_n = 1'b1;
						nxt_s.memw_n = 1'b1;
						nxt_s.refresh_n = 1'b1;
						if (!s_ff.cdma && !s_ff.cref && !s_ff.cmd[CMD_WR]) begin
							nxt_s.rdat = sd_s;
						end
						if (s_ff.cdma && s_ff.last && s_ff.dcfg[DCF_AUTO]) begin
							nxt_s.eop_o = 1'b0;
						end
					end else begin
						nxt_s.tcnt = s_ff.tcnt + 4'h1;
					end
				end
			end
			ST_END: begin
				if (se) begin
					nxt_s.st = ST_IDLE;
					nxt_s.aen = 1'b0;
					nxt_s.eop_o = 1'b0;
					nxt_s.sd_oe = 1'b0;
					nxt_s.sbhe_n = 1'b1;
					nxt_s.refresh_oe = 1'b0;
					if (s_ff.cref) begin
						nxt_s.rfa = s_ff.rfa + 8'h01;
					end
					if (s_ff.cdma) begin
						nxt_s.daddr = s_ff.daddr + 32'h00000001;
						nxt_s.dcnt = s_ff.dcnt - 16'h0001;
						if (s_ff.last || s_ff.eoph) begin
							nxt_s.eoph = 1'b0;
							if (s_ff.dcfg[DCF_AUTO]) begin
								nxt_s.daddr = s_ff.dbase;
								nxt_s.dcnt = s_ff.dcbase;
							end else begin
								nxt_s.drun = 1'b0;
							end
						end
					end
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase

		// a new request outranks the clear of one just taken
		if (s_ff.ref_prev && !ref_n_s && !s_ff.refresh_oe) begin
			nxt_s.xref = 1'b1;
		end

		// acknowledge lines, polarity from bit 7
		act = nxt_s.granted ? onehot(nxt_s.chan) : 8'h00;
		nxt_s.dack = act ^ {8{~s_ff.ctrl[CTL_DACK_POL]}};
		nxt_s.eop_oe = ~(s_ff.dcfg[DCF_EOPIN] & nxt_s.granted);
		nxt_s.cmd_oe = ~mst;
		if (mst) begin
			nxt_s.sd_oe = 1'b0;
		end
		nxt_s.m16_oe = mst & (~memr_n_s | ~memw_n_s)
			& (la_s >= s_ff.ctrl[CTL_PCIB_MSB:CTL_PCIB_LSB]);
		nxt_s.smemr_n = (mst ? memr_n_s : s_ff.memr_n)
			| ~(mst ? (la_s[6:3] == 4'h0) : (s_ff.caddr < ADDR_1M));
		nxt_s.smemw_n = (mst ? memw_n_s : s_ff.memw_n)
			| ~(mst ? (la_s[6:3] == 4'h0) : (s_ff.caddr < ADDR_1M));
		nxt_s.rstdrv = s_ff.ctrl[CTL_RSTDRV];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= RST_S;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign sysclk = s_ff.sysclk;
	assign bale = s_ff.bale;
	assign aen = s_ff.aen;
	assign rstdrv = s_ff.rstdrv;
	assign la_o = s_ff.caddr[23:17];
	assign sa_o = s_ff.caddr[19:0];
	assign addr_oe = s_ff.cmd_oe;
	assign ior_n_o = s_ff.ior_n;
	assign iow_n_o = s_ff.iow_n;
	assign memr_n_o = s_ff.memr_n;
	assign memw_n_o = s_ff.memw_n;
	assign cmd_oe = s_ff.cmd_oe;
	assign sbhe_n_o = s_ff.sbhe_n;
	assign sbhe_n_oe = s_ff.cmd_oe;
	assign smemr_n = s_ff.smemr_n;
	assign smemw_n = s_ff.smemw_n;
	assign memcs16_n_o = s_ff.tc_seen & 1'b0;
	assign memcs16_n_oe = s_ff.m16_oe;
	assign sd_o = s_ff.sd_o;
	assign sd_oe = s_ff.sd_oe;
	assign dack = s_ff.dack;
	assign eop_o = s_ff.eop_o;
	assign eop_oe = s_ff.eop_oe;
	assign refresh_n_o = s_ff.refresh_n;
	assign refresh_n_oe = s_ff.refresh_oe;
endmodule : isab_bridge
`default_nettype wire

/* File: dv/isab_checker.sv */
// isab_checker: port-level assertions for isab_bridge
// assumes one pclk domain with asynchronous active-low presetn
`timescale 1ns/1ns
`default_nettype none
module isab_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic aen,
	input wire logic rstdrv,
	input wire logic memr_n_o,
	input wire logic memw_n_o,
	input wire logic ior_n_o,
	input wire logic iow_n_o,
	input wire logic cmd_oe,
	input wire logic addr_oe,
	input wire logic sbhe_n_o,
	input wire logic sbhe_n_oe,
	input wire logic smemr_n,
	input wire logic memcs16_n_o,
	input wire logic memcs16_n_oe,
	input wire logic sd_oe,
	input wire logic [7:0] dack,
	input wire logic eop_o,
	input wire logic refresh_n_o,
	input wire logic refresh_n_oe
);
	logic own_ref;
	assign own_ref = refresh_n_oe && !refresh_n_o;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ref_sbhe; own_ref |-> sbhe_n_o; endproperty
	a_ref_sbhe: assert property (p_ref_sbhe) else $error("byte-high active in refresh");
	property p_ref_cmd; own_ref |-> memw_n_o && ior_n_o && iow_n_o; endproperty
	a_ref_cmd: assert property (p_ref_cmd) else $error("wrong strobe in refresh");
	property p_ref_aen; own_ref |-> aen; endproperty
	a_ref_aen: assert property (p_ref_aen) else $error("aen low in refresh");
	property p_smemr; cmd_oe && $past(cmd_oe) && !smemr_n |-> $past(memr_n_o) == 1'b0; endproperty
	a_smemr: assert property (p_smemr) else $error("smemr not a delayed memr");
	property p_mst_in; !cmd_oe |-> !sd_oe && !sbhe_n_oe && !addr_oe; endproperty
	a_mst_in: assert property (p_mst_in) else $error("lines driven under master");
	property p_cs16; memcs16_n_oe |-> !memcs16_n_o && !cmd_oe; endproperty
	a_cs16: assert property (p_cs16) else $error("memcs16 pulled outside master");
	property p_rel_ack; $rose(presetn) |-> dack == 8'hFF; endproperty
	a_rel_ack: assert property (p_rel_ack) else $error("dack active after reset");
	property p_rel_pins; $rose(presetn) |-> rstdrv && !refresh_n_oe && !sd_oe && !aen; endproperty
	a_rel_pins: assert property (p_rel_pins) else $error("bad pins after reset");
	property p_tc_aen; !aen && $past(aen) == 1'b0 |-> !eop_o; endproperty
	a_tc_aen: assert property (p_tc_aen) else $error("tc outside aen");
endmodule : isab_checker

bind isab_bridge isab_checker isab_checker_i (.pclk, .presetn, .aen, .rstdrv, .memr_n_o,
	.memw_n_o, .ior_n_o, .iow_n_o, .cmd_oe, .addr_oe, .sbhe_n_o, .sbhe_n_oe, .smemr_n,
	.memcs16_n_o, .memcs16_n_oe, .sd_oe, .dack, .eop_o, .refresh_n_o, .refresh_n_oe);
`default_nettype wire

/* File: dv/isab_slave.sv */
// isab_slave: isa slave, dma requester and bus master model
// assumes the bench changes its mode inputs only between cycles
`timescale 1ns/1ns
`default_nettype none
module isab_slave #(
	parameter logic [15:0] RDATA = 16'hC35A
) (
	input wire logic pclk,
	input wire logic cyc_n,
	input wire logic zw,
	input wire logic slow,
	input wire logic wide,
	input wire logic pol_req,
	input wire logic pol_ack,
	input wire logic [7:0] want,
	input wire logic mst,
	input wire logic [7:0] dack,
	output logic [15:0] sd_i,
	output logic zerows_n,
	output logic iochrdy,
	output logic memcs16_n_i,
	output logic [7:0] dreq,
	output logic master_n
);
	logic [7:0] act;
	logic [3:0] lo_n;
	assign act = pol_ack ? dack : ~dack;
	// bench holds want until well past the acknowledge
	assign dreq = pol_req ? ~want : want;
	assign memcs16_n_i = !wide;
	initial begin
		{zerows_n, iochrdy, master_n} = 3'b111;
		sd_i = 16'h0;
		lo_n = 4'h0;
	end
	always @(posedge pclk) begin
		lo_n <= cyc_n ? 4'h0 : lo_n + 4'(lo_n != 4'hF);
		// released data lines toggle instead of holding
		sd_i <= cyc_n ? ~sd_i : RDATA;
		zerows_n <= !(zw && !cyc_n && (!slow || lo_n < 4'hF));
		iochrdy <= !(slow && !cyc_n && lo_n < 4'hF);
		master_n <= !(mst && (act[5] || !master_n));
	end
endmodule : isab_slave
`default_nettype wire

/* File: dv/test_isab_bridge.sv */
// test_isab_bridge: directed apb tests of the isa bus engine
// assumes pclk at 100 MHz and isab_slave on the isa pins
`timescale 1ns/1ns
`default_nettype none
module test_isab_bridge;
	import isab_pkg::*;
	localparam int SC = 14; // pclks per sysclk at divisor 6
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sysclk, bale, aen, rstdrv;
	logic addr_oe, ior_n_o, iow_n_o, memr_n_o, memw_n_o, memr_n_i, memw_n_i, cmd_oe;
	logic sbhe_n_o, sbhe_n_oe, sbhe_n_i, smemr_n, smemw_n, memcs16_n_i, memcs16_n_o;
	logic memcs16_n_oe, master_n, zerows_n, iochrdy, sd_oe, eop_i, eop_o, eop_oe;
	logic refresh_n_i, refresh_n_o, refresh_n_oe, cyc_n, zw, slow, wide, mst, pr, pa, slv;
	logic [31:0] pwdata, prdata, rd;
	logic [19:0] sa_o;
	logic [15:0] sd_i, sd_o;
	logic [7:0] paddr, dreq, dack, want, ak;
	logic [6:0] la_o, la_i;
	logic [4:0] snap, fl;
	logic [1:0] smem;
	logic [3:0] cm [8];
	logic [2:0] zs [8];
	logic [3:0] ln [8];
	int err_total, n_checks, lo;
	assign cyc_n = memr_n_o & memw_n_o & ior_n_o & iow_n_o;
	isab_bridge isab_bridge_i (.*);
	isab_slave isab_slave_i (.pclk, .cyc_n, .zw, .slow, .wide, .pol_req(pr), .pol_ack(pa),
		.want, .mst, .dack, .sd_i, .zerows_n, .iochrdy, .memcs16_n_i, .dreq, .master_n);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// one own cycle; lo = pclks with a strobe low
	task automatic isa(input logic [3:0] c, input logic [31:0] a, input logic [2:0] m);
		{zw, slow, wide} <= m;
		apb(OFS_ADDR, 1'b1, a);
		apb(OFS_DATA, 1'b1, 32'h0000_A55A);
		apb(OFS_CMD, 1'b1, {28'h0, c});
		lo = 0;
		for (int n = 0; n < 300 && cyc_n !== 1'b0; n++)
			@(posedge pclk);
		snap = {aen, refresh_n_o, sbhe_n_o, memr_n_o, memw_n_o};
		while (cyc_n === 1'b0 && lo < 300) begin
			@(posedge pclk);
			lo++;
			if (lo == 3)
				smem = {smemr_n, smemw_n};
		end
		repeat (3 * SC) @(posedge pclk);
	endtask : isa
	// two-transfer run on channel 1; fl = {memr, memw, smemw, tc, aen} seen
	task automatic dma(input logic [11:0] g, input logic [31:0] a);
		fl = 5'h0;
		apb(OFS_DMACFG, 1'b1, {20'h0, g});
		apb(OFS_DMAADR, 1'b1, a);
		apb(OFS_DMACNT, 1'b1, 32'h1);
		want <= 8'h02;
		repeat (700) begin
			@(posedge pclk);
			fl |= {!memr_n_o, !memw_n_o, !smemw_n, eop_o, aen};
			if (ior_n_o === 1'b0)
				ak = dack;
		end
		want <= 8'h00;
		repeat (100) @(posedge pclk);
	endtask : dma
	initial begin
		repeat (30000) @(posedge pclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		{presetn, psel, penable, pwrite, zw, slow, wide, mst, pr, pa, eop_i} = '0;
		{memr_n_i, memw_n_i, sbhe_n_i, refresh_n_i} = '1;
		{paddr, pwdata, la_i, want, ak} = '0;
		{err_total, n_checks} = '0;
		cm = '{4'h4, 4'h4, 4'h0, 4'h0, 4'h5, 4'h1, 4'hC, 4'h4};
		zs = '{3'b001, 3'b101, 3'b100, 3'b000, 3'b101, 3'b100, 3'b101, 3'b111};
		ln = '{LEN_MEM16, LEN_MEM16_ZW, LEN_B8_ZW, LEN_B8, LEN_IO16, LEN_B8_ZW, LEN_MEM16_ZW,
			LEN_MEM16};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		check(32'({rstdrv, aen, sd_oe, refresh_n_oe, eop_o, eop_oe, smemr_n, smemw_n, dack}),
			32'h87FF);
		@(posedge pclk);
		apb(OFS_CTRL, 1'b0, 32'h0);
		check(rd, 32'(CTRL_RST));
		apb(8'h20, 1'b0, 32'h0);
		check(32'(slv), 32'h1);
		repeat (100) @(posedge pclk);
		apb(OFS_CTRL, 1'b1, 32'h0000_080C);
		repeat (2) @(posedge pclk);
		check(32'(rstdrv), 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			isa(cm[i], 32'h0000_1000, zs[i]);
			check(32'(lo), 32'((ln[i] - 4'h1 + 4'(zs[i][1])) * SC));
			check(32'(snap[2]), 32'(!cm[i][2]));
		end
		isa(4'h4, 32'h0000_1000, 3'b001);
		check(32'(smem), 32'h1);
		apb(OFS_DATA, 1'b0, 32'h0);
		check(rd, 32'h0000_C35A);
		isa(4'hC, 32'h0020_0000, 3'b001);
		check(32'(smem), 32'h3);
		isa(4'h2, 32'h0, 3'b000);
		check(32'(snap), 32'h15);
		check(32'(lo), 32'((LEN_REF - 4'h1) * SC));
		refresh_n_i <= 1'b0;
		for (int n = 0; n < 300 && memr_n_o !== 1'b0; n++)
			@(posedge pclk);
		check(32'({memr_n_o, aen, refresh_n_oe, sbhe_n_o}), 32'h5);
		refresh_n_i <= 1'b1;
		repeat (5 * SC) @(posedge pclk);
		$display("test cycles done");
		dma(12'h202, 32'h0200_0000);
		check(32'(fl), 32'h03);
		check(32'(ak), 32'hFD);
		dma(12'h202, 32'h0000_8000);
		check(32'(fl), 32'h0F);
		dma(12'h302, 32'h0000_8000);
		check(32'(fl), 32'h03);
		eop_i <= 1'b1;
		dma(12'hA02, 32'h0000_8000);
		eop_i <= 1'b0;
		check(32'(fl), 32'h0D);
		apb(OFS_DMACNT, 1'b0, 32'h0);
		check(rd, 32'h0);
		apb(OFS_DMACFG, 1'b1, 32'h0);
		apb(OFS_CTRL, 1'b1, 32'h0000_08CC);
		{pr, pa} <= 2'b11;
		dma(12'h202, 32'h0000_8000);
		check(32'(ak), 32'h02);
		apb(OFS_DMACFG, 1'b1, 32'h0);
		{pr, pa} <= 2'b00;
		apb(OFS_CTRL, 1'b1, 32'h0000_080C);
		$display("test dma done");
		apb(OFS_DMACFG, 1'b1, 32'h0000_0020);
		{mst, want} <= {1'b1, 8'h20};
		for (int n = 0; n < 300 && master_n !== 1'b0; n++)
			@(posedge pclk);
		{la_i, memr_n_i} <= {7'h10, 1'b0};
		repeat (8) @(posedge pclk);
		check(32'({cmd_oe, sd_oe, memcs16_n_oe}), 32'h1);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		check(32'(dack), 32'hFF);
		{memr_n_i, mst, want, presetn} <= {1'b1, 1'b0, 8'h00, 1'b1};
		repeat (5) @(posedge pclk);
		$display("test master done");
		tally_and_finish();
	end
endmodule : test_isab_bridge
`default_nettype wire
